// file: src/lmspd_pkg.sv
// package for the led matrix scan pwm dimmer
// assumes one 250 MHz clock shared by all users of these constants
package lmspd_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_ORDER    = 8'h04;
  localparam logic [7:0] ADDR_TIMING   = 8'h08;
  localparam logic [7:0] ADDR_DEGHOST  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_DOT_BASE = 8'h40;
  localparam logic [7:0] ADDR_PWM_BASE = 8'h80;
  localparam int         NUM_DOTS      = 16;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int         MODE_MIX_LSB    = 4;
  localparam int         TIM_BLANK_BIT   = 1;
  localparam int         TIM_SYNC_BIT    = 2;
  localparam int         TIM_PEAK_BIT    = 3;
  localparam int         DG_CLAMPSEL_BIT = 1;
  localparam int         DG_VMID_LSB     = 2;
  localparam int         PWM_ALIGN_LSB   = 8;
  localparam int         PWM_EXP_BIT     = 10;
  localparam logic [7:0] ORDER_RESET     = 8'he4;
  localparam logic [7:0] DOT_RESET       = 8'h80;
  localparam logic [7:0] DOT_FULL        = 8'hff;

  // ************************************************************
  // timing: 6 MHz time base from a 250 MHz clock
  // ************************************************************
  localparam int CLK_MHZ        = 250;
  localparam int TBASE_KHZ      = 6000;
  localparam int TBASE_DIV      = (CLK_MHZ * 1000) / TBASE_KHZ;
  localparam int TICKS_FAST     = 256;
  localparam int BLANK1_NS      = 1000;
  localparam int BLANK2_NS      = 2000;
  localparam int BLANK1_TICKS   = (BLANK1_NS * TBASE_KHZ) / 1000000;
  localparam int BLANK2_TICKS   = (BLANK2_NS * TBASE_KHZ) / 1000000;

  typedef enum logic [1:0] {
    LMSPD_ALIGN_FWD = 2'b00,
    LMSPD_ALIGN_MID = 2'b01,
    LMSPD_ALIGN_BWD = 2'b10
  } lmspd_align_t;

  typedef enum logic [0:0] {
    LMSPD_PH_DIM   = 1'b0,
    LMSPD_PH_BLANK = 1'b1
  } lmspd_phase_t;

  typedef struct packed {
    logic [3:0] sink_en;
    logic [3:0] switch_en;
    logic [3:0] clamp_en;
  } lmspd_drive_t;

endpackage : lmspd_pkg

// file: src/lmspd_top.sv
// led matrix scan pwm dimmer: topology, scan sequencing, dimming, clamp
// assumes an apb master on pclk; analog cells consume drive outputs
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module lmspd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe,
  output logic      [3:0]  sink_on,
  output logic      [3:0]  switch_on,
  output logic      [3:0]  clamp_on,
  output logic      [1:0]  clamp_level,
  output logic             global_peak_range,
  output logic      [7:0]  dot_current_level [4]
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]  mode_reg;
  logic [7:0]  order_reg;
  logic [3:0]  timing_reg;
  logic [3:0]  deghost_config_reg;
  logic [7:0]  dot_reg   [lmspd_pkg::NUM_DOTS];
  logic [10:0] pwm_reg   [lmspd_pkg::NUM_DOTS];
  logic        wr_en;
  logic [3:0]  idx;
  logic        in_dot;
  logic        in_pwm;
  logic        mapped;

  assign wr_en  = psel & penable & pwrite;
  assign idx    = paddr[5:2];
  assign in_dot = paddr[7:6] == lmspd_pkg::ADDR_DOT_BASE[7:6];
  assign in_pwm = paddr[7:6] == lmspd_pkg::ADDR_PWM_BASE[7:6];
  assign mapped = in_dot | in_pwm | paddr == lmspd_pkg::ADDR_MODE
                | paddr == lmspd_pkg::ADDR_ORDER
                | paddr == lmspd_pkg::ADDR_TIMING
                | paddr == lmspd_pkg::ADDR_DEGHOST
                | paddr == lmspd_pkg::ADDR_STATUS;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // host orders writes mode, order, mask; each takes effect at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg           <= 8'h00;
      order_reg          <= lmspd_pkg::ORDER_RESET;
      timing_reg         <= 4'h0;
      deghost_config_reg <= 4'h0;
    end else if (clk_en && wr_en) begin
      if (paddr == lmspd_pkg::ADDR_MODE) mode_reg <= pwdata[7:0];
      if (paddr == lmspd_pkg::ADDR_ORDER) order_reg <= pwdata[7:0];
      if (paddr == lmspd_pkg::ADDR_TIMING) timing_reg <= pwdata[3:0];
      if (paddr == lmspd_pkg::ADDR_DEGHOST) begin
        deghost_config_reg <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < lmspd_pkg::NUM_DOTS; i++) begin
        dot_reg[i] <= lmspd_pkg::DOT_RESET;
        pwm_reg[i] <= 11'h000;
      end
    end else if (clk_en && wr_en) begin
      if (in_dot) dot_reg[idx] <= pwdata[7:0];
      if (in_pwm) pwm_reg[idx] <= pwdata[10:0];
    end
  end

  // ************************************************************
  // time base and sync pin
  // ************************************************************
  logic [5:0] div_reg;
  logic       osc_tick;
  logic       sync_s1_reg;
  logic       sync_s2_reg;
  logic       sync_s3_reg;
  logic       tick;
  logic       sync_is_in;

  assign sync_is_in = timing_reg[lmspd_pkg::TIM_SYNC_BIT];
  assign osc_tick   = div_reg ==
                      6'(lmspd_pkg::TBASE_DIV - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= 6'h00;
    else if (clk_en) div_reg <= osc_tick ? 6'h00 : div_reg + 6'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
    end else if (clk_en) begin
      sync_s1_reg <= sync_in;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  // external rising edge or internal divider
  assign tick = sync_is_in ? (sync_s2_reg & ~sync_s3_reg) : osc_tick;

  // pin drives the time base out unless set as input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sync_out <= 1'b0;
    else if (clk_en) begin
      if (osc_tick) sync_out <= 1'b1;
      else if (div_reg == 6'(lmspd_pkg::TBASE_DIV / 2)) sync_out <= 1'b0;
    end
  end
  assign sync_oe = ~sync_is_in;

  // ************************************************************
  // scan sequencer
  // ************************************************************
  lmspd_pkg::lmspd_phase_t phase_reg;
  logic [8:0] step_reg;
  logic [7:0] step;
  logic [1:0] slot_reg;
  logic [2:0] scans;
  logic       slow;
  logic       period_end;
  logic       blank_end;
  logic [8:0] blank_len;
  logic [2:0] mode;

  assign mode  = mode_reg[2:0];
  assign slow  = timing_reg[0];
  // slow rate advances the step on every second tick
  assign step  = slow ? step_reg[8:1] : step_reg[7:0];
  assign scans = mode == 3'd0 ? 3'd1 :
                 mode <= 3'd4 ? mode : mode - 3'd4;
  assign blank_len = timing_reg[lmspd_pkg::TIM_BLANK_BIT] ?
                     9'(lmspd_pkg::BLANK2_TICKS) :
                     9'(lmspd_pkg::BLANK1_TICKS);
  // >= also ends a count that a shorter rate or blank has overtaken
  assign period_end = step_reg >= (slow ? 9'h1ff : 9'h0ff);
  assign blank_end  = step_reg >= blank_len - 9'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= lmspd_pkg::LMSPD_PH_DIM;
      step_reg  <= 9'h000;
      slot_reg  <= 2'h0;
    end else if (clk_en && tick) begin
      case (phase_reg)
        lmspd_pkg::LMSPD_PH_DIM: begin
          step_reg <= step_reg + 9'h001;
          if (period_end) begin
            step_reg  <= 9'h000;
            phase_reg <= lmspd_pkg::LMSPD_PH_BLANK;
          end
        end
        lmspd_pkg::LMSPD_PH_BLANK: begin
          step_reg <= step_reg + 9'h001;
          if (blank_end) begin
            step_reg  <= 9'h000;
            phase_reg <= lmspd_pkg::LMSPD_PH_DIM;
            // frame wraps after the configured slot count
            slot_reg  <= ({1'b0, slot_reg} + 3'd1 >= scans) ? 2'h0 :
                         slot_reg + 2'h1;
          end
        end
        default: phase_reg <= lmspd_pkg::LMSPD_PH_DIM;
      endcase
    end
  end

  // ************************************************************
  // pwm and drive
  // ************************************************************
  logic [3:0] sw_out;
  logic [1:0] anode;
  logic [3:0] mix_mask;
  logic       scanning;
  logic [3:0] pulse;
  logic [3:0] sink_n;
  logic [3:0] sw_n;
  logic [3:0] clamp_n;
  logic       blanking;

  assign anode    = order_reg[2*slot_reg +: 2];
  assign scanning = mode != 3'd0;
  assign mix_mask = mode >= 3'd5 ? mode_reg[lmspd_pkg::MODE_MIX_LSB +: 4]
                                 : 4'h0;
  assign blanking = phase_reg == lmspd_pkg::LMSPD_PH_BLANK;

  // simple squared curve as exponential map
  function automatic logic [7:0] lmspd_curve(input logic [7:0] v,
                                             input logic       ex);
    logic [15:0] sq;
    sq = v * v;
    lmspd_curve = ex ? sq[15:8] + {7'h00, |v} : v;
  endfunction : lmspd_curve

  function automatic logic lmspd_pulse(input logic [7:0] st,
                                       input logic [7:0] d,
                                       input logic [1:0] al);
    logic [8:0] lo;
    lo = 9'h000;
    case (al)
      lmspd_pkg::LMSPD_ALIGN_FWD: lmspd_pulse = st < d;
      lmspd_pkg::LMSPD_ALIGN_MID: begin
        lo = 9'(8'h80 - {1'b0, d[7:1]});
        lmspd_pulse = {1'b0, st} >= lo && {1'b0, st} < lo + {1'b0, d};
      end
      lmspd_pkg::LMSPD_ALIGN_BWD: lmspd_pulse = {1'b0, st} >=
                                  9'h100 - {1'b0, d};
      default: lmspd_pulse = st < d;
    endcase
  endfunction : lmspd_pulse

  // dot index: direct dots 0..3; matrix dot 4+anode*3+y
  always_comb begin
    logic [3:0] d_idx;
    logic [1:0] y;
    d_idx   = 4'h0;
    y       = 2'h0;
    sink_n  = 4'h0;
    sw_n    = 4'h0;
    pulse   = 4'h0;
    clamp_n = 4'h0;
    for (int o = 0; o < 4; o++) begin
      y = 2'(o) - anode - 2'h1;
      if (!scanning || mix_mask[o]) d_idx = 4'(o);
      else d_idx = 4'(4 + 3 * anode + y);
      pulse[o] = lmspd_pulse(step, lmspd_curve(pwm_reg[d_idx][7:0],
                   pwm_reg[d_idx][lmspd_pkg::PWM_EXP_BIT]),
                   pwm_reg[d_idx][lmspd_pkg::PWM_ALIGN_LSB +: 2]);
      dot_current_level[o] = dot_reg[d_idx];
      if (scanning && !mix_mask[o] && 2'(o) == anode) begin
        sw_n[o] = ~blanking;
      end else begin
        sink_n[o] = ~blanking & pulse[o];
      end
      // clamp in blank, or also in pwm-off remainder
      clamp_n[o] = blanking | (deghost_config_reg[
                   lmspd_pkg::DG_CLAMPSEL_BIT] & ~sink_n[o] & ~sw_n[o]);
    end
    if (deghost_config_reg[0]) clamp_n = 4'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_on   <= 4'h0;
      switch_on <= 4'h0;
      clamp_on  <= 4'h0;
    end else if (clk_en) begin
      sink_on   <= sink_n;
      switch_on <= sw_n;
      clamp_on  <= clamp_n;
    end
  end

  assign clamp_level = deghost_config_reg[lmspd_pkg::DG_VMID_LSB +: 2];
  assign global_peak_range = timing_reg[lmspd_pkg::TIM_PEAK_BIT];

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == lmspd_pkg::ADDR_MODE) prdata <= {24'h0, mode_reg};
      if (paddr == lmspd_pkg::ADDR_ORDER) prdata <= {24'h0, order_reg};
      if (paddr == lmspd_pkg::ADDR_TIMING) prdata <= {28'h0, timing_reg};
      if (paddr == lmspd_pkg::ADDR_DEGHOST) begin
        prdata <= {28'h0, deghost_config_reg};
      end
      if (paddr == lmspd_pkg::ADDR_STATUS) begin
        // status packs step, slot and phase
        prdata <= {20'h0, step_reg, slot_reg, phase_reg};
      end
      if (in_dot) prdata <= {24'h0, dot_reg[idx]};
      if (in_pwm) prdata <= {21'h0, pwm_reg[idx]};
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_ONE_SWITCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    $countones(switch_on) <= 1) else $error("more than one switch");
  AST_NO_SW_DIRECT: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) && $past(mode_reg[2:0]) == 3'd0 |-> switch_on == 4'h0)
    else $error("switch in direct mode");
  AST_CLAMP_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) && $past(deghost_config_reg[0]) |-> clamp_on == 4'h0)
    else $error("clamp while disabled");
  AST_BLANK_DARK: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(blanking) && $past(clk_en) |->
      sink_on == 4'h0 && switch_on == 4'h0)
    else $error("drive during blank");
  AST_SLOT_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && tick && blanking && blank_end |=>
      {1'b0, slot_reg} < $past(scans))
    else $error("slot beyond scan count");
  AST_SYNC_OE: assert property (
    @(posedge pclk) disable iff (!presetn)
    sync_oe == !timing_reg[lmspd_pkg::TIM_SYNC_BIT])
    else $error("sync direction wrong");
  AST_STEP_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tick |=> $stable(step_reg)) else $error("step moved off tick");
  AST_MIX_NOSW: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) && $past(mode_reg[2:0]) >= 3'd5 |->
      (switch_on & $past(mix_mask)) == 4'h0)
    else $error("switch on direct output");
  AST_BLANK_CLAMP: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) && $past(blanking) && !$past(deghost_config_reg[0]) |->
      clamp_on == 4'hf)
    else $error("no clamp during blank");
  AST_DIM_WRAP: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && tick && !blanking && period_end |=>
      blanking && step_reg == 9'h000)
    else $error("pwm period did not end in blank");
  AST_EXT_TICK: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && sync_is_in && sync_s2_reg && !sync_s3_reg && !blanking &&
      !period_end |=> step_reg == $past(step_reg) + 9'h001)
    else $error("external edge did not advance step");

endmodule : lmspd_top

`default_nettype wire

// file: tb/lmspd_led_matrix.sv
// led matrix model hanging on the four output pins of the dimmer
// assumes drive levels are registered and sampled on pclk
`timescale 1ns/1ns
`default_nettype none

module lmspd_led_matrix (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  sink_on,
  input  wire logic [3:0]  switch_on,
  output logic      [31:0] lit [16],
  output logic      [31:0] err_cnt
);
  // ************************************************************
  // lit time per anode and cathode, index anode*4+cathode
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lit     <= '{default: '0};
      err_cnt <= '0;
    end else begin
      for (int a = 0; a < 4; a++) begin
        for (int c = 0; c < 4; c++) begin
          // no switch on: direct dot sits on the diagonal
          if (sink_on[c] && ((switch_on == 4'h0) ? (a == c) : switch_on[a]))
            lit[a*4+c] <= lit[a*4+c] + 32'h1;
        end
      end
      // two switches, or a pin both switching and sinking
      if ($countones(switch_on) > 1 || (switch_on & sink_on) != 4'h0)
        err_cnt <= err_cnt + 32'h1;
    end
  end
endmodule : lmspd_led_matrix

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the led matrix scan pwm dimmer
// assumes apb at 250 MHz and the led matrix model on the pins
`timescale 1ns/1ns
`default_nettype none

module tb;
  localparam int TD = lmspd_pkg::TBASE_DIV;
  localparam int BT = lmspd_pkg::BLANK2_TICKS;
  logic        pclk, presetn, psel, penable, pwrite, sync_in, clk_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, base, err_cnt;
  logic        pready, pslverr, sync_out, sync_oe, er, global_peak_range;
  logic [3:0]  sink_on, switch_on, clamp_on;
  logic [1:0]  clamp_level;
  logic [7:0]  dot_current_level [4];
  logic [31:0] lit [16];
  int          n_errors, num_checks, cyc, t0;

  lmspd_top u_lmspd_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
    .sink_on(sink_on), .switch_on(switch_on), .clamp_on(clamp_on),
    .clamp_level(clamp_level), .global_peak_range(global_peak_range),
    .dot_current_level(dot_current_level));
  lmspd_led_matrix u_lmspd_led_matrix (.pclk(pclk), .presetn(presetn),
    .sink_on(sink_on), .switch_on(switch_on), .lit(lit), .err_cnt(err_cnt));

  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ************************************************************
  // apb master and compare tasks
  // ************************************************************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask : rchk

  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // pin k: 0-3 sink, 4-7 switch, 8 sync out
  function automatic logic sel(input int k);
    logic [8:0] v;
    v = {sync_out, switch_on, sink_on};
    return v[k];
  endfunction : sel

  task automatic wl(input int k, input logic lvl);
    do @(negedge pclk); while (sel(k) !== lvl);
  endtask : wl

  task automatic span(input string nm, input int exp);
    chk(nm, 32'(exp), 32'(cyc - t0));
  endtask : span

  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; sync_in = 0; cyc = 0; t0 = 0;
    n_errors = 0; num_checks = 0;
    clk_en = 1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk("mode", lmspd_pkg::ADDR_MODE, 32'h0);
    rchk("order", lmspd_pkg::ADDR_ORDER, 32'h0000_00e4);
    rchk("timing", lmspd_pkg::ADDR_TIMING, 32'h0);
    rchk("deghost", lmspd_pkg::ADDR_DEGHOST, 32'h0);
    rchk("dot level 0", 8'h40, 32'h0000_0080);
    rchk("dot level 15", 8'h7c, 32'h0000_0080);
    xfer(1'b0, 8'h20, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    chk("peak range", 32'h0, {31'h0, global_peak_range});
    chk("sync oe", 32'h1, {31'h0, sync_oe});
    wr(lmspd_pkg::ADDR_TIMING, 32'h8);
    wr(lmspd_pkg::ADDR_DEGHOST, 32'hc);
    settle;
    chk("peak range", 32'h1, {31'h0, global_peak_range});
    chk("clamp level", 32'h3, {30'h0, clamp_level});
    wr(lmspd_pkg::ADDR_TIMING, 32'h4);
    settle;
    chk("sync oe", 32'h0, {31'h0, sync_oe});
    // external controller supplies the common time base
    xfer(1'b0, lmspd_pkg::ADDR_STATUS, 32'h0, base, er);
    repeat (5) begin
      sync_in <= 1'b1;
      repeat (2) @(posedge pclk);
      sync_in <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    xfer(1'b0, lmspd_pkg::ADDR_STATUS, 32'h0, rd, er);
    chk("ext ticks", 32'h5, 32'(rd[11:3] - base[11:3]));
    wr(lmspd_pkg::ADDR_TIMING, 32'h0);
    wl(8, 1'b0);
    wl(8, 1'b1);
    t0 = cyc;
    wl(8, 1'b0);
    wl(8, 1'b1);
    span("sync period", TD);
    wr(lmspd_pkg::ADDR_DEGHOST, 32'h0);
    wr(8'h44, 32'h33);
    settle;
    chk("dot out1", 32'h33, {24'h0, dot_current_level[1]});
    chk("dot out0", 32'h80, {24'h0, dot_current_level[0]});
    // a write while the clock enable is low must not land
    @(posedge pclk);
    clk_en <= 1'b0;
    wr(8'h48, 32'h11);
    clk_en <= 1'b1;
    rchk("frozen write", 8'h48, 32'h0000_0080);
    // direct drive: fwd, bwd, mid, exp fwd, duty 40h
    wr(8'h80, 32'h040);
    wr(8'h84, 32'h240);
    wr(8'h88, 32'h140);
    wr(8'h8c, 32'h440);
    wl(0, 1'b0);
    wl(0, 1'b1);
    t0 = cyc;
    wl(3, 1'b0);
    span("exp width", 17 * TD);
    wl(0, 1'b0);
    span("fwd width", 64 * TD);
    wl(2, 1'b1);
    span("mid start", 96 * TD);
    wl(1, 1'b1);
    span("bwd start", 192 * TD);
    chk("direct switch", 32'h0, {28'h0, switch_on});
    wr(lmspd_pkg::ADDR_TIMING, 32'h1);
    wl(0, 1'b0);
    wl(0, 1'b1);
    t0 = cyc;
    wl(0, 1'b0);
    span("slow width", 64 * 2 * TD);
    // two scans: slot0 output 2, slot1 output 0, 2 us blank
    wr(lmspd_pkg::ADDR_MODE, 32'h2);
    wr(lmspd_pkg::ADDR_ORDER, 32'h2);
    wr(8'ha8, 32'h040);
    wr(lmspd_pkg::ADDR_TIMING, 32'h2);
    wl(6, 1'b0);
    wl(6, 1'b1);
    t0 = cyc;
    base = lit[11];
    wl(6, 1'b0);
    span("switch on-time", 256 * TD);
    repeat (BT * TD / 2) @(posedge pclk);
    @(negedge pclk);
    chk("blank switch", 32'h0, {28'h0, switch_on});
    chk("blank clamp", 32'h1, {31'h0, clamp_on != 4'h0});
    wl(4, 1'b1);
    span("next slot", (256 + BT) * TD);
    wl(6, 1'b1);
    span("frame", 2 * (256 + BT) * TD);
    chk("dot a2 y0", 32'(64 * TD), lit[11] - base);
    // mixed drive: one slot switching output 0, output 3 direct
    wr(lmspd_pkg::ADDR_MODE, 32'h05);
    wr(lmspd_pkg::ADDR_ORDER, 32'h00);
    wr(lmspd_pkg::ADDR_MODE, 32'h85);
    wr(8'h50, 32'h5a);
    wr(lmspd_pkg::ADDR_DEGHOST, 32'h2);
    settle;
    chk("mix switch", 32'h1, {28'h0, switch_on});
    chk("mix dot y0", 32'h5a, {24'h0, dot_current_level[1]});
    chk("mix direct dot", 32'h80, {24'h0, dot_current_level[3]});
    chk("pwm-off clamp", 32'h1, {31'h0, clamp_on[1]});
    wr(lmspd_pkg::ADDR_DEGHOST, 32'h1);
    settle;
    chk("clamp disabled", 32'h0, {28'h0, clamp_on});
    chk("pin conflicts", 32'h0, err_cnt);
    give_verdict;
  end

  initial begin
    repeat (99000) @(posedge pclk);
    n_errors++;
    give_verdict;
  end
endmodule : tb

`default_nettype wire
